// *** dv/ppc_periph.sv ***
// partner model: cycle engine requests seen by the control block
// assumes the bench picks the wanted request levels
`timescale 1ns/100ps
`default_nettype none
module ppc_periph (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // wanted levels, latch then chip select
    input  wire logic [1:0] want,
    // requests into the block
    output logic            latch_req,
    output logic            cs1_req
);
    // requests move only after an edge, low while in reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) {latch_req, cs1_req} <= 2'h0;
        else {latch_req, cs1_req} <= want;
    end
endmodule // ppc_periph
`default_nettype wire

// *** dv/test_parallel_port_control_config.sv ***
// bench: register port tasks and steering checks of the control block
// assumes one 40 MHz clock and the control word at index 0
`timescale 1ns/100ps
`default_nettype none
module test_parallel_port_control_config;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, device_idle = 0, mode_16bit = 1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [1:0] want = 2'h0, mux;
    logic latch_req, cs1_req, act, be, wr, rd, sel, addr_latch_polarity, cs;
    logic [2:0] pol;
    int fails = 0, check_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    ppc_periph peer (.clk_sys(clk_sys), .rst_n(rst_n), .want(want), .latch_req(latch_req), .cs1_req(cs1_req));
    ppc_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
        .mode_16bit(mode_16bit), .latch_req(latch_req), .cs1_req(cs1_req), .port_active(act),
        .addr_data_mux_select(mux), .byte_enable_pin_enable(be), .write_strobe_pin_enable(wr),
        .read_strobe_pin_enable(rd), .chip_select1_is_select(sel), .addr_latch_low_pin(addr_latch_polarity),
        .chip_select1_pin(cs), .strobe_polarity(pol));
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // let registered outputs catch up, then compare steering vector
    task automatic pins(input logic [15:0] exp);
        repeat (3) @(posedge clk_sys);
        #1 chk({4'h0, act, mux, be, wr, rd, sel, addr_latch_polarity, cs, pol}, exp);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard, 4000 cycles, far beyond the roughly 50 cycles the tests need
    initial begin
        #100us fails++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(4'h0, ppc_pkg::CTRL_RESET);
        wr_reg(ppc_pkg::CTRL_OFFSET, 16'hFFFF);
        rd_chk(4'h0, 16'hBFEF);
        rd_chk(4'h5, 16'h0000);
        pins(16'h0FC7);
        want <= 2'h3;
        pins(16'h0FD7);
        mode_16bit <= 1'b0;
        pins(16'h0ED7);
        device_idle <= 1'b1;
        mode_16bit <= 1'b1;
        pins(16'h0607);
        wr_reg(4'h0, 16'h80A8);
        pins(16'h0838);
        wr_reg(4'h0, 16'h8080);
        pins(16'h0820);
        wr_reg(4'h0, 16'h0000);
        pins(16'h0010);
        close_out;
    end
endmodule // test_parallel_port_control_config
`default_nettype wire

// *** logic/ppc_ctrl.sv ***
// control register of the parallel master port and its pin steering
// assumes a device idle level on the system clock and a strobe register port
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ppc_ctrl (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // device state and sixteen-bit master mode
    input  wire logic        device_idle,
    input  wire logic        mode_16bit,
    // raw port activity from the cycle engine
    input  wire logic        latch_req,
    input  wire logic        cs1_req,
    // steering outputs
    output logic             port_active,
    output logic [1:0]       addr_data_mux_select,
    output logic             byte_enable_pin_enable,
    output logic             write_strobe_pin_enable,
    output logic             read_strobe_pin_enable,
    output logic             chip_select1_is_select,
    output logic             addr_latch_low_pin,
    output logic             chip_select1_pin,
    output logic [2:0]       strobe_polarity
);
    // control word state
    logic [15:0] ctrl_q;        // stored control word
    logic [15:0] ctrl_d;        // next control word

    // read return state
    logic [15:0] rdata_q;       // read data, one cycle behind strobe
    logic [15:0] rdata_d;       // next read data

    // steering state
    logic [14:0] pins_q;        // registered steering outputs
    logic [14:0] pins_d;        // next steering outputs

    // decoded control fields, all plain combinational nets
    logic        run;           // port allowed to run
    logic [1:0]  csf;           // chip select function field
    logic        cs_sel;        // cs1 pin serves as chip select
    logic        latch_active;  // logical latch request, gated by run
    logic        cs1_active;    // logical cs1 request, gated by run

    // address decode, shared by the write and read paths
    // so both always agree on where the control word sits
    function automatic logic hits_ctrl(input logic [3:0] addr);
        hits_ctrl = (addr == ppc_pkg::CTRL_OFFSET);
    endfunction

    // logical request to pin level
    // a set polarity bit means active high, a cleared one active low,
    // so an idle pin rests at the inverse of its polarity bit
    function automatic logic to_pin(input logic active, input logic active_high);
        to_pin = active_high ? active : !active;
    endfunction

    // next control word
    // writes elsewhere in the map leave the word alone;
    // the mask keeps the two unimplemented positions at zero
    always_comb begin
        ctrl_d = ctrl_q;                                 // hold by default
        if (reg_wr && hits_ctrl(reg_addr)) begin
            ctrl_d = reg_wdata & ppc_pkg::CTRL_MASK;
        end
    end

    // control word register, clears at reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= ppc_pkg::CTRL_RESET;               // all fields off
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // next read data
    // zero outside the cycle after a read, so a stale word never
    // lingers on the bus; unmapped addresses read zero as well
    always_comb begin
        rdata_d = 16'h0000;                              // idle bus reads zero
        if (reg_rd) begin
            if (hits_ctrl(reg_addr)) begin
                rdata_d = ctrl_q;
            end
        end
    end

    // read data register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // decoded fields and next steering outputs
    // everything goes through one more flop so the pins never glitch
    // on a register write; the cost is one cycle of lag after a write
    always_comb begin
        // chip select function: only 10 makes cs1 a select,
        // the reserved 11 is treated like an address line
        csf          = ctrl_q[ppc_pkg::BIT_CSF_LO +: 2];
        cs_sel       = (csf == ppc_pkg::CSF_CHIPSEL);
        // idle only stops the port when software asked for it
        run          = ctrl_q[ppc_pkg::BIT_EN]
                       && !(ctrl_q[ppc_pkg::BIT_IDLE] && device_idle);
        // a stopped port makes no off-chip activity
        latch_active = run && latch_req;
        cs1_active   = run && cs1_req;
        // run flag and address/data multiplexing
        pins_d[0]     = run;
        pins_d[2:1]   = ctrl_q[ppc_pkg::BIT_MUX_LO +: 2];
        // strobe pin enables, byte enable only in sixteen-bit mode
        pins_d[3]     = run && mode_16bit && ctrl_q[ppc_pkg::BIT_BE_EN];
        pins_d[4]     = run && ctrl_q[ppc_pkg::BIT_WR_EN];
        pins_d[5]     = run && ctrl_q[ppc_pkg::BIT_RD_EN];
        pins_d[6]     = cs_sel;
        // address latch strobe level from its polarity bit
        pins_d[7]     = to_pin(latch_active, ctrl_q[ppc_pkg::BIT_ALP]);
        // cs1 as an address line: polarity does not apply, pin held low
        if (cs_sel) begin
            pins_d[8] = to_pin(cs1_active, ctrl_q[ppc_pkg::BIT_CHIP_SELECT1_POLARITY]);
        end else begin
            pins_d[8] = 1'b0;
        end
        // remaining polarity bits are only stored and exported
        pins_d[11:9]  = {ctrl_q[ppc_pkg::BIT_BEP], ctrl_q[ppc_pkg::BIT_WRITE_STROBE_POLARITY],
                         ctrl_q[ppc_pkg::BIT_READ_STROBE_POLARITY]};
        // spare flops, tied low
        pins_d[14:12] = 3'h0;
    end

    // steering register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pins_q <= 15'h0000;                          // every output low in reset
        end else begin
            pins_q <= pins_d;
        end
    end

    // outputs, each a straight copy of a flop
    assign reg_rdata               = rdata_q;
    assign port_active             = pins_q[0];
    assign addr_data_mux_select    = pins_q[2:1];
    assign byte_enable_pin_enable  = pins_q[3];
    assign write_strobe_pin_enable = pins_q[4];
    assign read_strobe_pin_enable  = pins_q[5];
    assign chip_select1_is_select  = pins_q[6];
    assign addr_latch_low_pin      = pins_q[7];
    assign chip_select1_pin        = pins_q[8];
    assign strobe_polarity         = pins_q[11:9];

    // checks, gathered after the outputs at the end of the module
    // every one names its clock and its reset itself

    // a write to the control word
    sequence s_ctrl_write;
        reg_wr && hits_ctrl(reg_addr);
    endsequence

    // a plain read of the control word
    sequence s_ctrl_read;
        reg_rd && hits_ctrl(reg_addr) && !reg_wr;
    endsequence

    // a read of an unmapped index
    sequence s_other_read;
        reg_rd && !hits_ctrl(reg_addr);
    endsequence

    // port switched off by software
    sequence s_port_off;
        !ctrl_q[ppc_pkg::BIT_EN];
    endsequence

    // idle with stop-in-idle requested
    sequence s_idle_stop;
        ctrl_q[ppc_pkg::BIT_IDLE] && device_idle;
    endsequence

    // latch requested while running, active-high polarity
    sequence s_latch_req_high;
        run && latch_req && ctrl_q[ppc_pkg::BIT_ALP];
    endsequence

    // cs1 requested as a select, active-high polarity
    sequence s_cs_req_high;
        cs_sel && run && cs1_req && ctrl_q[ppc_pkg::BIT_CHIP_SELECT1_POLARITY];
    endsequence

    // cs1 not a select: it serves as an address line
    sequence s_cs_addr_line;
        !chip_select1_is_select;
    endsequence

    // unimplemented positions never hold a one
    a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl_q & ~ppc_pkg::CTRL_MASK) == 16'h0000)
        else $error("unimplemented bit set");

    // read data is the word seen at the strobe
    a_read_late: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_ctrl_read |=> reg_rdata == $past(ctrl_q))
        else $error("read data wrong");

    // unmapped index reads zero
    a_read_other: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_other_read |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

    // no read strobe, no read data
    a_read_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");

    // a write lands masked in the next cycle
    a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_ctrl_write |=> ctrl_q == ($past(reg_wdata) & ppc_pkg::CTRL_MASK))
        else $error("write did not land");

    // disabled port drives no write or read strobe pin enable
    a_disable_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_port_off |=> !port_active && !write_strobe_pin_enable && !read_strobe_pin_enable)
        else $error("port active while disabled");

    // enabled port without idle stop runs
    a_enable_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_q[ppc_pkg::BIT_EN] && !ctrl_q[ppc_pkg::BIT_IDLE] |=> port_active)
        else $error("enabled port not running");

    // idle stops the port when asked
    a_idle_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_idle_stop |=> !port_active)
        else $error("ran in idle");

    // idle alone does not stop the port
    a_idle_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_q[ppc_pkg::BIT_EN] && !ctrl_q[ppc_pkg::BIT_IDLE] && device_idle |=> port_active)
        else $error("stopped in idle unasked");

    // multiplexing output follows the field
    a_mux_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> addr_data_mux_select == $past(ctrl_q[12:11]))
        else $error("mux stale");

    // byte enable only in sixteen-bit mode
    a_be_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !mode_16bit |=> !byte_enable_pin_enable)
        else $error("byte enable in 8-bit");

    // byte enable on when asked in sixteen-bit mode
    a_be_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && mode_16bit && ctrl_q[ppc_pkg::BIT_BE_EN] |=> byte_enable_pin_enable)
        else $error("byte enable missing");

    // write strobe pin off when its bit is clear
    a_wr_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl_q[ppc_pkg::BIT_WR_EN] |=> !write_strobe_pin_enable)
        else $error("wr pin without bit");

    // write strobe pin on when its bit is set
    a_wr_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && ctrl_q[ppc_pkg::BIT_WR_EN] |=> write_strobe_pin_enable)
        else $error("wr pin missing");

    // read strobe pin off while the port runs means its bit was clear
    a_rd_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        port_active && !read_strobe_pin_enable |-> !$past(ctrl_q[8]))
        else $error("rd pin");

    // read strobe pin on when its bit is set
    a_rd_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        run && ctrl_q[ppc_pkg::BIT_RD_EN] |=> read_strobe_pin_enable)
        else $error("rd pin missing");

    // only code 10 makes cs1 a chip select
    a_cs_function: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_q[ppc_pkg::BIT_CSF_LO +: 2] != ppc_pkg::CSF_CHIPSEL |=> !chip_select1_is_select)
        else $error("cs1 select on wrong code");

    // active-high latch strobe goes high on request
    a_latch_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_latch_req_high |=> addr_latch_low_pin)
        else $error("latch strobe not high");

    // active-low latch strobe rests high
    a_latch_rest: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !latch_req && !ctrl_q[ppc_pkg::BIT_ALP] |=> addr_latch_low_pin)
        else $error("latch strobe not resting");

    // active-high chip select goes high on request
    a_cs_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_cs_req_high |=> chip_select1_pin)
        else $error("cs1 not high");

    // active-low chip select rests high
    a_cs_rest: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cs_sel && !cs1_req && !ctrl_q[ppc_pkg::BIT_CHIP_SELECT1_POLARITY] |=> chip_select1_pin)
        else $error("cs1 not resting");

    // as an address line cs1 ignores its polarity
    a_cs_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_cs_addr_line |-> !chip_select1_pin)
        else $error("cs polarity on address");

    // stored polarity bits are exported as written
    a_pol_stored: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> strobe_polarity == $past(ctrl_q[2:0]))
        else $error("polarity bits stale");

    // the spare flops stay low
    a_spare_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pins_q[14:12] == 3'h0)
        else $error("spare flops set");
endmodule // ppc_ctrl
`default_nettype wire

// *** logic/ppc_pkg.sv ***
// constants of the parallel port control register block
// assumes a 16-bit control word reached over a plain strobe port
// How it works
// - global enable gates every off-chip access
// - stop-in-idle halts port while device idles
// - two-bit field picks address/data multiplexing
// - byte-enable pin enable, sixteen-bit mode only
// - write/enable strobe pin enable bit
// - read strobe pin enable bit
// - chip-select function: 10 select, 0x address
// - address latch polarity high or low
// - chip-select-1 polarity high or low
// - polarity ignored where pin is address
// - unimplemented bits ignore writes, read zero
package ppc_pkg;
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  CTRL_OFFSET  = 4'h0;  // control register index
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] CTRL_MASK    = 16'hBFEF; // bits 14 and 4 absent
    localparam int          BIT_EN       = 15;
    localparam int          BIT_IDLE     = 13;
    localparam int          BIT_MUX_LO   = 11;
    localparam int          BIT_BE_EN    = 10;
    localparam int          BIT_WR_EN    = 9;
    localparam int          BIT_RD_EN    = 8;
    localparam int          BIT_CSF_LO   = 6;
    localparam int          BIT_ALP      = 5;
    localparam int          BIT_CHIP_SELECT1_POLARITY     = 3;
    localparam int          BIT_BEP      = 2;
    localparam int          BIT_WRITE_STROBE_POLARITY     = 1;
    localparam int          BIT_READ_STROBE_POLARITY     = 0;
    localparam logic [1:0]  CSF_CHIPSEL  = 2'h2;
    localparam logic [1:0]  MUX_SEPARATE = 2'h3;
endpackage
